// ---- rtl/ctp_timers.sv ----
// timer 0 and timer 1 counter/timers with axi4-lite registers
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "ctp_timers_map.svh"
module ctp_timers (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic EXT_INPUT0,
  input wire logic EXT_INPUT1,
  output logic IRQ,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import ctp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [1:0] sync1_ff, sync2_ff;
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [11:0] ctl_ff, nxt_ctl;
  ctp_cnt_type cnt_ff [2];
  ctp_cnt_type nxt_cnt [2];
  logic [1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic do_wr, rd_take;
  logic [1:0] en, set_ovf, wr_cnt;
  ctp_mode_type mode [2];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // external input synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {EXT_INPUT1, EXT_INPUT0};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // axi4-lite handshake
  // ----------------------------------------
  assign S_AXI_AWREADY = !aw_hold_ff && !bvalid_ff;
  assign S_AXI_WREADY = !w_hold_ff && !bvalid_ff;
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign IRQ = irq_ff;
  assign do_wr = aw_hold_ff && w_hold_ff;
  assign rd_take = S_AXI_ARVALID && !rvalid_ff;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = S_AXI_WDATA;
      nxt_wstrb = S_AXI_WSTRB;
    end
    if (do_wr) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      unique case (awaddr_ff)
        `CTP_OFS_CTRL, `CTP_OFS_CNT0, `CTP_OFS_CNT1, `CTP_OFS_STAT,
        `CTP_OFS_MASK: nxt_bresp = `CTP_RESP_OKAY;
        default: nxt_bresp = `CTP_RESP_SLVERR;
      endcase
    end else if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (rd_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `CTP_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `CTP_OFS_CTRL: nxt_rdata = {20'h00000, ctl_ff};
        `CTP_OFS_CNT0: nxt_rdata = {16'h0000, cnt_ff[0]};
        `CTP_OFS_CNT1: nxt_rdata = {16'h0000, cnt_ff[1]};
        `CTP_OFS_STAT: nxt_rdata = {30'h00000000, stat_ff};
        `CTP_OFS_MASK: nxt_rdata = {30'h00000000, mask_ff};
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = `CTP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `CTP_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `CTP_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // timers, status and mask
  // ----------------------------------------
  always_comb begin
    logic [12:0] sum13;
    sum13 = 13'h0000;
    nxt_ctl = ctl_ff;
    nxt_mask = mask_ff;
    set_ovf = 2'h0;
    for (int i = 0; i < 2; i++) begin
      nxt_cnt[i] = cnt_ff[i];
      mode[i] = ctp_mode_type'(ctl_ff[`CTP_CTL_MODE + 2*i +: 2]);
      // same run/gate qualification in every mode
      en[i] = ctl_ff[`CTP_CTL_RUN + i] &&
              (!ctl_ff[`CTP_CTL_GATE + i] || (sync2_ff[i] == ctl_ff[`CTP_CTL_POL + i]));
      wr_cnt[i] = do_wr && (awaddr_ff == ((i == 0) ? `CTP_OFS_CNT0 : `CTP_OFS_CNT1));
      if (en[i]) begin
        unique case (mode[i])
          CTP_MODE13: begin
            sum13 = 13'({cnt_ff[i][15:8], cnt_ff[i][4:0]} + 13'h0001);
            set_ovf[i] = ({cnt_ff[i][15:8], cnt_ff[i][4:0]} == 13'h1FFF);
            nxt_cnt[i] = {sum13[12:5], cnt_ff[i][7:5], sum13[4:0]};
          end
          CTP_MODE16: begin
            // full 16-bit count, wraps to zero without reload
            set_ovf[i] = (cnt_ff[i] == 16'hFFFF);
            nxt_cnt[i] = cnt_ff[i] + 16'h0001;
          end
          CTP_MODE8R: begin
            // low byte counts, high byte left untouched
            if (cnt_ff[i][7:0] == 8'hFF) begin
              set_ovf[i] = 1'b1;
              nxt_cnt[i][7:0] = cnt_ff[i][15:8];
            end else begin
              nxt_cnt[i][7:0] = cnt_ff[i][7:0] + 8'h01;
            end
          end
          CTP_STOP: begin
            nxt_cnt[i] = cnt_ff[i];
          end
        endcase
      end
      if (wr_cnt[i]) begin
        nxt_cnt[i] = 16'(merge({16'h0000, cnt_ff[i]}, wdata_ff, wstrb_ff));
      end
    end
    if (do_wr && awaddr_ff == `CTP_OFS_CTRL) begin
      nxt_ctl = 12'(merge({20'h00000, ctl_ff}, wdata_ff, wstrb_ff));
    end
    if (do_wr && awaddr_ff == `CTP_OFS_MASK) begin
      nxt_mask = 2'(merge({30'h00000000, mask_ff}, wdata_ff, wstrb_ff));
    end
    // read clears, a new overflow in the same cycle wins
    nxt_stat = ((rd_take && S_AXI_ARADDR == `CTP_OFS_STAT) ? 2'h0 : stat_ff) | set_ovf;
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl_ff <= `CTP_RST_CTL;
      cnt_ff[0] <= `CTP_RST_CNT;
      cnt_ff[1] <= `CTP_RST_CNT;
      stat_ff <= 2'h0;
      mask_ff <= `CTP_RST_MASK;
      irq_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      cnt_ff[0] <= nxt_cnt[0];
      cnt_ff[1] <= nxt_cnt[1];
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_roll0;
    en[0] && mode[0] == CTP_MODE8R && cnt_ff[0][7:0] == 8'hFF && !wr_cnt[0];
  endsequence
  sequence s_reloaded0;
    cnt_ff[0][7:0] == $past(cnt_ff[0][15:8]) && stat_ff[0];
  endsequence
  property p_reload0;
    @(posedge CLK) disable iff (RESET) s_roll0 |=> s_reloaded0;
  endproperty
  a_reload0: assert property (p_reload0) else $error("timer0 reload missed");

  property p_reload1;
    @(posedge CLK) disable iff (RESET)
      en[1] && mode[1] == CTP_MODE8R && cnt_ff[1][7:0] == 8'hFF && !wr_cnt[1]
      |=> cnt_ff[1][7:0] == $past(cnt_ff[1][15:8]) && stat_ff[1];
  endproperty
  a_reload1: assert property (p_reload1) else $error("timer1 reload missed");

  property p_m2_count;
    @(posedge CLK) disable iff (RESET)
      en[0] && mode[0] == CTP_MODE8R && cnt_ff[0][7:0] != 8'hFF && !wr_cnt[0]
      |=> cnt_ff[0][7:0] == 8'($past(cnt_ff[0][7:0]) + 8'h01);
  endproperty
  a_m2_count: assert property (p_m2_count) else $error("low byte count wrong");

  property p_high_kept;
    @(posedge CLK) disable iff (RESET)
      !wr_cnt[0] && mode[0] != CTP_MODE13 && mode[0] != CTP_MODE16
      |=> $stable(cnt_ff[0][15:8]);
  endproperty
  a_high_kept: assert property (p_high_kept) else $error("reload byte changed");

  property p_m1_count;
    @(posedge CLK) disable iff (RESET)
      en[1] && mode[1] == CTP_MODE16 && !wr_cnt[1]
      |=> cnt_ff[1] == 16'($past(cnt_ff[1]) + 16'h0001);
  endproperty
  a_m1_count: assert property (p_m1_count) else $error("16-bit count wrong");

  sequence s_wrap0;
    en[0] && mode[0] == CTP_MODE16 && cnt_ff[0] == 16'hFFFF && !wr_cnt[0];
  endsequence
  sequence s_run16_0;
    en[0] && mode[0] == CTP_MODE16 && !wr_cnt[0];
  endsequence
  property p_m1_wrap;
    @(posedge CLK) disable iff (RESET) s_wrap0 |=> cnt_ff[0] == 16'h0000 && stat_ff[0];
  endproperty
  a_m1_wrap: assert property (p_m1_wrap) else $error("16-bit wrap wrong");

  property p_m1_after;
    @(posedge CLK) disable iff (RESET) s_wrap0 ##1 s_run16_0 |=> cnt_ff[0] == 16'h0001;
  endproperty
  a_m1_after: assert property (p_m1_after) else $error("count after wrap wrong");

  property p_irq;
    @(posedge CLK) disable iff (RESET)
      $rose(stat_ff[0]) && mask_ff[0] |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_hold_stop;
    @(posedge CLK) disable iff (RESET)
      !ctl_ff[`CTP_CTL_RUN] && !wr_cnt[0] |=> $stable(cnt_ff[0]) && !$rose(stat_ff[0]);
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("counted while stopped");

  property p_gate;
    @(posedge CLK) disable iff (RESET)
      ctl_ff[`CTP_CTL_RUN + 1] && ctl_ff[`CTP_CTL_GATE + 1] &&
      sync2_ff[1] != ctl_ff[`CTP_CTL_POL + 1] && !wr_cnt[1] |=> $stable(cnt_ff[1]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored");

endmodule // ctp_timers

// ---- rtl/ctp_timers_map.svh ----
// register map, field positions and reset values of the timer pair
`ifndef CTP_TIMERS_MAP_SVH
`define CTP_TIMERS_MAP_SVH
// ----------------------------------------
// byte offsets
// ----------------------------------------
`define CTP_OFS_CTRL 8'h00
`define CTP_OFS_CNT0 8'h04
`define CTP_OFS_CNT1 8'h08
`define CTP_OFS_STAT 8'h0C
`define CTP_OFS_MASK 8'h10
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTP_CTL_RUN 0
`define CTP_CTL_GATE 2
`define CTP_CTL_POL 4
`define CTP_CTL_MODE 8
// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define CTP_RST_CTL 12'h000
`define CTP_RST_CNT 16'h0000
`define CTP_RST_MASK 2'h0
`define CTP_RESP_OKAY 2'h0
`define CTP_RESP_SLVERR 2'h2
`endif

// ---- rtl/ctp_pkg.sv ----
// types of the timer pair
package ctp_pkg;
  typedef enum logic [1:0] {
    CTP_MODE13,
    CTP_MODE16,
    CTP_MODE8R,
    CTP_STOP
  } ctp_mode_type;
  typedef logic [15:0] ctp_cnt_type;
endpackage : ctp_pkg

// ---- sim/tb_ctp_timers.sv ----
// self-checking bench of the timer pair
`include "ctp_timers_map.svh"
module tb_ctp_timers;
  timeunit 1ns;
  timeprecision 100ps;
  import ctp_pkg::*;
  // ------
  // signals
  // ------
  logic clk, reset, ein0, ein1, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_total, checks;
  ctp_timers ctp_timers_i (.CLK(clk), .RESET(reset), .EXT_INPUT0(ein0), .EXT_INPUT1(ein1),
    .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t mismatch seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    bq.push_back(rsp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_in(input int t, input logic v);
    if (t != 0) ein1 <= v;
    else ein0 <= v;
  endtask
  function automatic logic [16:0] model(ctp_mode_type m, ctp_cnt_type c, int n);
    logic ov;
    ov = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (m == CTP_MODE13) begin
        {c[15:8], c[4:0]} = {c[15:8], c[4:0]} + 13'h0001;
        ov |= ({c[15:8], c[4:0]} == 13'h0000);
      end else if (m == CTP_MODE16) begin
        c = c + 16'h0001;
        ov |= (c == 16'h0000);
      end else if (m == CTP_MODE8R) begin
        if (c[7:0] == 8'hFF) begin
          c[7:0] = c[15:8];
          ov = 1'b1;
        end else c[7:0] = c[7:0] + 8'h01;
      end
    end
    return {ov, c};
  endfunction
  task automatic run_case(input int t, input ctp_mode_type m, input ctp_cnt_type st,
                          input int n, input logic pol, input logic run, input logic msk);
    logic [16:0] r;
    logic [7:0] oa;
    oa = (t != 0) ? `CTP_OFS_CNT1 : `CTP_OFS_CNT0;
    r = model(m, st, run ? n : 0);
    axi_wr(`CTP_OFS_CTRL, 32'h0, `CTP_RESP_OKAY);
    set_in(t, !pol);
    axi_wr(oa, {16'h0000, st}, `CTP_RESP_OKAY);
    axi_wr(`CTP_OFS_MASK, 32'(msk) << t, `CTP_RESP_OKAY);
    axi_wr(`CTP_OFS_CTRL, (32'(run) << t) | (32'h4 << t) | (32'(pol) << (4 + t))
           | (32'(m) << (8 + 2 * t)), `CTP_RESP_OKAY);
    repeat (3) @(posedge clk);
    set_in(t, pol);
    repeat (n) @(posedge clk);
    set_in(t, !pol);
    repeat (4) @(posedge clk);
    chk(34'(irq), 34'(r[16] & msk));
    axi_rd(oa, {18'h0, r[15:0]});
    axi_rd(`CTP_OFS_STAT, 34'(r[16]) << t);
    repeat (2) @(posedge clk);
    chk(34'(irq), 34'h0);
  endtask
  // ------
  // result watcher
  // ------
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  // ------
  // sequence
  // ------
  initial begin
    int t;
    int seed;
    ctp_mode_type m;
    ctp_cnt_type st;
    reset = 1'b1;
    {ein0, ein1, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    err_total = 0;
    checks = 0;
    seed = $urandom(48006);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axi_rd(`CTP_OFS_CTRL, 34'h0);
    run_case(0, CTP_MODE8R, 16'hF0FD, 5, 1'b1, 1'b1, 1'b1);
    run_case(0, CTP_MODE16, 16'hFFFE, 4, 1'b0, 1'b1, 1'b1);
    run_case(1, CTP_MODE8R, 16'h30FE, 3, 1'b0, 1'b1, 1'b0);
    run_case(1, CTP_MODE8R, 16'h80FF, 9, 1'b1, 1'b1, 1'b1);
    run_case(1, CTP_MODE16, 16'hFFFF, 6, 1'b1, 1'b0, 1'b1);
    run_case(0, CTP_MODE13, 16'hFFFE, 3, 1'b1, 1'b1, 1'b1);
    run_case(1, CTP_STOP, 16'h12FF, 5, 1'b0, 1'b1, 1'b1);
    axi_wr(8'h14, 32'h000000A5, `CTP_RESP_SLVERR);
    axi_rd(8'h14, {`CTP_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 10; i++) begin
      t = int'($urandom % 2);
      m = ($urandom % 2) != 0 ? CTP_MODE16 : CTP_MODE8R;
      st = ctp_cnt_type'($urandom);
      st[7:4] = 4'hF;
      if (m == CTP_MODE16) st[15:8] = 8'hFF;
      run_case(t, m, st, 1 + int'($urandom % 40), 1'($urandom), 1'b1, 1'($urandom));
    end
    tally_and_finish();
  end
endmodule // tb_ctp_timers
